// [hw/dspps_top.sv]
// Two serial channels with modem lines, infrared lines and power-on straps
// Function
// [R01] Each channel takes its receive pin level from the link.
// [R02] Transmit pins drive serial data once reset has ended. Channel B's wire pin is held high while the infrared route is selected.
// [R03] Modem pulls ring indication low while ringing.
// [R04] Modem pulls carrier detect low while carrier is present.
// [R05] Modem holds dataset ready low when ready to link.
// [R06] Clear-to-send level reads in bit 4 of each channel status.
// [R07] Terminal-ready output goes low when controller is ready.
// [R08] Request-to-send output goes low when ready to send.
// [R09] Channel A terminal-ready strap sets index port select bit.
// [R10] Channel A request-to-send strap sets plug-and-play defaults bit 2.
// [R11] Channel A transmit strap enables or disables the floppy controller.
// [R12] Channel B transmit strap high selects serial interrupt mode.
// [R13] Channel B request-to-send strap sets interrupt or GPIO bits 4, 5.
// [R14] Second infrared channel has one transmit and one receive line.
// [R15] System holds master reset active to reset, inactive otherwise.
// [R16] Host supplies the bus clock in serial interrupt mode.
// [R17] Straps latch at reset release, then pins return to outputs.
`timescale 1ns/100ps
`include "dspps_defs.svh"
module dspps_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Channel A modem and data
    input  wire logic        serial_in_chan_a,
    input  wire logic        ring_indication_a_n,
    input  wire logic        carrier_detect_a_n,
    input  wire logic        dataset_ready_a_n,
    input  wire logic        clear_to_send_a_n,
    input  wire logic        terminal_ready_a_i,
    output logic             terminal_ready_a_o,
    output logic             terminal_ready_a_oe,
    input  wire logic        request_send_a_i,
    output logic             request_send_a_o,
    output logic             request_send_a_oe,
    input  wire logic        serial_out_chan_a_i,
    output logic             serial_out_chan_a_o,
    output logic             serial_out_chan_a_oe,
    // Channel B modem and data
    input  wire logic        serial_in_chan_b,
    input  wire logic        ring_indication_b_n,
    input  wire logic        carrier_detect_b_n,
    input  wire logic        dataset_ready_b_n,
    input  wire logic        clear_to_send_b_n,
    output logic             terminal_ready_b_n,
    input  wire logic        request_send_b_i,
    output logic             request_send_b_o,
    output logic             request_send_b_oe,
    input  wire logic        serial_out_chan_b_i,
    output logic             serial_out_chan_b_o,
    output logic             serial_out_chan_b_oe,
    // Second infrared channel
    output logic             infrared_tx_second,
    input  wire logic        infrared_rx_second,
    // Latched strap results
    output logic             index_port_select_bit,
    output logic             pnp_defaults_bit,
    output logic             floppy_enable,
    output logic             serial_irq_mode,
    output logic             pin_zero_irq_gpio_select,
    output logic             pin_one_irq_gpio_select
);
    logic [4:0]  ctrl_r;
    logic [4:0]  strap_r;
    logic        pins_on_r;
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;
    logic [1:0]  tx_line;
    logic [1:0]  tx_busy;
    logic [1:0]  tx_ready;
    logic [1:0]  tx_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [8:0]  fifo_out_data;

    // Strap capture: pins read continuously while reset is held, frozen after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_r   <= {request_send_b_i, serial_out_chan_b_i, serial_out_chan_a_i,
                          request_send_a_i, terminal_ready_a_i}; // [R17]
            pins_on_r <= 1'b0;
        end else begin
            pins_on_r <= 1'b1; // [R17]
        end
    end

    // Strap meanings; pull resistors sit outside this logic
    assign index_port_select_bit    = strap_r[0]; // [R09]
    assign pnp_defaults_bit         = strap_r[1]; // [R10]
    assign floppy_enable            = strap_r[2]; // [R11]
    assign serial_irq_mode          = strap_r[3]; // [R12]
    assign pin_zero_irq_gpio_select = strap_r[4]; // [R13]
    assign pin_one_irq_gpio_select  = strap_r[4]; // [R13]

    // Shared pins stay released until the straps are frozen
    wire ir_b = ctrl_r[`DSPPS_CTRL_IR_B];
    assign terminal_ready_a_oe  = pins_on_r; // [R17]
    assign request_send_a_oe    = pins_on_r;
    assign serial_out_chan_a_oe = pins_on_r;
    assign request_send_b_oe    = pins_on_r;
    assign serial_out_chan_b_oe = pins_on_r;
    assign terminal_ready_a_o   = !ctrl_r[`DSPPS_CTRL_DTR_A]; // [R07]
    assign request_send_a_o     = !ctrl_r[`DSPPS_CTRL_RTS_A]; // [R08]
    assign terminal_ready_b_n   = !ctrl_r[`DSPPS_CTRL_DTR_B]; // [R07]
    assign request_send_b_o     = !ctrl_r[`DSPPS_CTRL_RTS_B]; // [R08]
    assign serial_out_chan_a_o  = tx_line[0]; // [R02]
    // Infrared route parks the wire line idle high; wire route holds the IR line low
    assign serial_out_chan_b_o  = ir_b ? 1'b1 : tx_line[1]; // [R02]
    assign infrared_tx_second   = ir_b ? tx_line[1] : 1'b0; // [R14]

    // Status words: modem inputs shown as raw pin levels
    wire rx_b = ir_b ? infrared_rx_second : serial_in_chan_b; // [R14]
    wire [31:0] stat_a = {26'h000_0000, tx_busy[0], clear_to_send_a_n, dataset_ready_a_n,
                          carrier_detect_a_n, ring_indication_a_n, serial_in_chan_a}; // [R01] [R06]
    wire [31:0] stat_b = {26'h000_0000, tx_busy[1], clear_to_send_b_n, dataset_ready_b_n,
                          carrier_detect_b_n, ring_indication_b_n, rx_b}; // [R01] [R06]
    wire [31:0] strap_w = {26'h000_0000, strap_r[4], strap_r[4], 1'b0, strap_r[1], 1'b0, strap_r[0]};
    wire [31:0] aux_w   = {30'h0000_0000, strap_r[3], strap_r[2]};

    // Read decode
    wire rd_ctrl = (s_axi_araddr == `DSPPS_OFF_CTRL);
    wire rd_sa   = (s_axi_araddr == `DSPPS_OFF_STAT_A);
    wire rd_sb   = (s_axi_araddr == `DSPPS_OFF_STAT_B);
    wire rd_txd  = (s_axi_araddr == `DSPPS_OFF_TXDATA);
    wire rd_st   = (s_axi_araddr == `DSPPS_OFF_STRAP);
    wire rd_aux  = (s_axi_araddr == `DSPPS_OFF_STRAP_AUX);
    wire rd_hit  = rd_ctrl | rd_sa | rd_sb | rd_txd | rd_st | rd_aux;
    wire [31:0] rd_mux = rd_ctrl ? {27'h000_0000, ctrl_r} :
                         rd_sa   ? stat_a :
                         rd_sb   ? stat_b :
                         rd_txd  ? {31'h0000_0000, fifo_in_ready} :
                         rd_st   ? strap_w :
                         rd_aux  ? aux_w : 32'h0000_0000;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    // Write decode; a full FIFO holds the write until room appears
    wire wr_ctrl = (awaddr_r == `DSPPS_OFF_CTRL);
    wire wr_txd  = (awaddr_r == `DSPPS_OFF_TXDATA);
    wire wr_ro   = (awaddr_r == `DSPPS_OFF_STAT_A) | (awaddr_r == `DSPPS_OFF_STAT_B) |
                   (awaddr_r == `DSPPS_OFF_STRAP) | (awaddr_r == `DSPPS_OFF_STRAP_AUX);
    wire wr_go   = aw_hold_r && w_hold_r && !bvalid_r && (!wr_txd || fifo_in_ready);
    wire fifo_push = wr_go && wr_txd && wstrb_r[0];

    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready  = !w_hold_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // Address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 32'h0000_0000;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && !w_hold_r) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // Write response and control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `DSPPS_RESP_OK;
            ctrl_r   <= `DSPPS_CTRL_RST;
        end else begin
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= (wr_ctrl | wr_txd | wr_ro) ? `DSPPS_RESP_OK : `DSPPS_RESP_ERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (wr_go && wr_ctrl && wstrb_r[0]) begin
                ctrl_r <= wdata_r[4:0];
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `DSPPS_RESP_OK;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_hit ? `DSPPS_RESP_OK : `DSPPS_RESP_ERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Shared transmit queue; bit 8 picks the channel
    dspps_fifo #(.W(9), .D(`DSPPS_FIFO_DEPTH)) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (wdata_r[8:0]),
        .out_valid (fifo_out_valid),
        .out_ready (tx_ready[fifo_out_data[`DSPPS_TXD_CHAN]]),
        .out_data  (fifo_out_data)
    );

    // One serialiser per channel; the queue stalls while the head entry's channel is busy
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tx
            assign tx_valid[gi] = fifo_out_valid && (fifo_out_data[`DSPPS_TXD_CHAN] == 1'(gi));
            dspps_tx u_tx (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .in_valid (tx_valid[gi]),
                .in_ready (tx_ready[gi]),
                .in_data  (fifo_out_data[7:0]),
                .txd      (tx_line[gi]),
                .busy     (tx_busy[gi])
            );
        end
    endgenerate

    // Checks
    property p_rx_level;
        @(posedge aclk) disable iff (!aresetn)
        ar_take && rd_sa |=> s_axi_rdata[0] == $past(serial_in_chan_a);
    endproperty
    a_rx_level: assert property (p_rx_level) else $error("rx level not reported"); // [R01]
    property p_cts_bit;
        @(posedge aclk) disable iff (!aresetn)
        ar_take && rd_sb |=> s_axi_rdata[`DSPPS_STAT_CTS] == $past(clear_to_send_b_n);
    endproperty
    a_cts_bit: assert property (p_cts_bit) else $error("cts not in bit 4"); // [R06]
    property p_tx_drive;
        @(posedge aclk) disable iff (!aresetn)
        pins_on_r && !tx_busy[0] |-> serial_out_chan_a_oe && serial_out_chan_a_o;
    endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("idle tx not driven high"); // [R02]
    property p_dtr_low;
        @(posedge aclk) disable iff (!aresetn)
        wr_go && wr_ctrl && wstrb_r[0] && wdata_r[0] |=> !terminal_ready_a_o;
    endproperty
    a_dtr_low: assert property (p_dtr_low) else $error("terminal ready not asserted"); // [R07]
    property p_rts_low;
        @(posedge aclk) disable iff (!aresetn)
        wr_go && wr_ctrl && wstrb_r[0] && wdata_r[3] |=> !request_send_b_o;
    endproperty
    a_rts_low: assert property (p_rts_low) else $error("request to send not asserted"); // [R08]
    property p_strap_a;
        @(posedge aclk) disable iff (!aresetn)
        $rose(pins_on_r) |-> index_port_select_bit == $past(terminal_ready_a_i, 2) &&
                             pnp_defaults_bit == $past(request_send_a_i, 2) &&
                             floppy_enable == $past(serial_out_chan_a_i, 2);
    endproperty
    a_strap_a: assert property (p_strap_a) else $error("channel A strap mislatched"); // [R09] [R10] [R11]
    property p_strap_b;
        @(posedge aclk) disable iff (!aresetn)
        $rose(pins_on_r) |-> serial_irq_mode == $past(serial_out_chan_b_i, 2) &&
                             pin_one_irq_gpio_select == $past(request_send_b_i, 2);
    endproperty
    a_strap_b: assert property (p_strap_b) else $error("channel B strap mislatched"); // [R12] [R13]
    property p_strap_hold;
        @(posedge aclk) disable iff (!aresetn)
        pins_on_r |=> $stable(strap_r) && serial_out_chan_b_oe;
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after release"); // [R17]
    property p_ir_route;
        @(posedge aclk) disable iff (!aresetn)
        ir_b && tx_busy[1] |-> infrared_tx_second == tx_line[1] && serial_out_chan_b_o;
    endproperty
    a_ir_route: assert property (p_ir_route) else $error("infrared route wrong"); // [R14]
    c_tx_frame: cover property (@(posedge aclk) disable iff (!aresetn) tx_valid[0] && tx_ready[0]);
    c_fifo_full: cover property (@(posedge aclk) disable iff (!aresetn) !fifo_in_ready);
    c_release: cover property (@(posedge aclk) disable iff (!aresetn) $rose(pins_on_r));
    c_bad_addr: cover property (@(posedge aclk) disable iff (!aresetn) ar_take && !rd_hit);
endmodule

// [hw/dspps_defs.svh]
// Offsets, field positions, reset values and timing counts of the serial pin block
`ifndef DSPPS_DEFS_SVH
`define DSPPS_DEFS_SVH
`define DSPPS_OFF_CTRL      32'h0000_0000
`define DSPPS_OFF_STAT_A    32'h0000_0004
`define DSPPS_OFF_STAT_B    32'h0000_0008
`define DSPPS_OFF_TXDATA    32'h0000_000C
`define DSPPS_OFF_STRAP     32'h0000_0010
`define DSPPS_OFF_STRAP_AUX 32'h0000_0014
`define DSPPS_CTRL_RST      5'h00
`define DSPPS_CTRL_DTR_A    0
`define DSPPS_CTRL_RTS_A    1
`define DSPPS_CTRL_DTR_B    2
`define DSPPS_CTRL_RTS_B    3
`define DSPPS_CTRL_IR_B     4
`define DSPPS_STAT_CTS      4
`define DSPPS_STRAP_IDX     0
`define DSPPS_STRAP_PNP     2
`define DSPPS_STRAP_G0      4
`define DSPPS_STRAP_G1      5
`define DSPPS_TXD_CHAN      8
`define DSPPS_CLK_HZ        25000000
`define DSPPS_BAUD          115200
`define DSPPS_BIT_CYC       (`DSPPS_CLK_HZ / `DSPPS_BAUD)
`define DSPPS_FIFO_DEPTH    32
`define DSPPS_RESP_OK       2'h0
`define DSPPS_RESP_ERR      2'h2
`endif

// [hw/dspps_pkg.sv]
// Types shared by the serial pin block
package dspps_pkg;
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b11,
        TX_STOP  = 2'b10
    } dspps_tx_state_t;
endpackage

// [hw/dspps_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module dspps_fifo #(
    parameter int W = 9,
    parameter int D = 32
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wptr_r;
    logic [AW:0]  rptr_r;
    wire          full  = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
    wire          empty = (wptr_r == rptr_r);
    wire          push  = in_valid && !full;
    wire          pop   = out_valid && out_ready;

    // Honest flags straight from the pointers
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rptr_r[AW-1:0]];

    // Storage write
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wptr_r[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end
endmodule

// [hw/dspps_tx.sv]
// Serialiser: one start bit, eight data bits LSB first, one stop bit
`timescale 1ns/100ps
`include "dspps_defs.svh"
module dspps_tx (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Byte in
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    // Line
    output logic            txd,
    output logic            busy
);
    localparam logic [15:0] BIT_CYC = 16'(`DSPPS_BIT_CYC);
    dspps_pkg::dspps_tx_state_t st_r;
    logic [15:0] cnt_r;
    logic [7:0]  sh_r;
    logic [2:0]  nbit_r;
    logic        txd_r;
    wire         tick = (cnt_r == BIT_CYC - 16'h0001);

    // Idle line is high
    assign in_ready = (st_r == dspps_pkg::TX_IDLE);
    assign txd      = txd_r;
    assign busy     = !in_ready;

    // Bit timing and framing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r   <= dspps_pkg::TX_IDLE;
            cnt_r  <= 16'h0000;
            sh_r   <= 8'h00;
            nbit_r <= 3'h0;
            txd_r  <= 1'b1;
        end else begin
            cnt_r <= (st_r == dspps_pkg::TX_IDLE || tick) ? 16'h0000 : cnt_r + 16'h0001;
            unique case (st_r)
                dspps_pkg::TX_IDLE: begin
                    if (in_valid) begin
                        sh_r  <= in_data;
                        txd_r <= 1'b0;
                        st_r  <= dspps_pkg::TX_START;
                    end
                end
                dspps_pkg::TX_START: begin
                    if (tick) begin
                        txd_r  <= sh_r[0];
                        sh_r   <= {1'b0, sh_r[7:1]};
                        nbit_r <= 3'h0;
                        st_r   <= dspps_pkg::TX_DATA;
                    end
                end
                dspps_pkg::TX_DATA: begin
                    if (tick) begin
                        nbit_r <= nbit_r + 3'h1;
                        txd_r  <= (nbit_r == 3'h7) ? 1'b1 : sh_r[0];
                        sh_r   <= {1'b0, sh_r[7:1]};
                        if (nbit_r == 3'h7) begin
                            st_r <= dspps_pkg::TX_STOP;
                        end
                    end
                end
                dspps_pkg::TX_STOP: begin
                    if (tick) begin
                        st_r <= dspps_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// [bench/dspps_modem.sv]
// Far side model: modem lines and the board's strap resistors
`timescale 1ns/100ps
module dspps_modem #(
    parameter logic [4:0] PULL = 5'h06
) (
    // Strap-shared pins, order rts b, sout b, sout a, rts a, dtr a
    input  wire logic [4:0] pin_o,
    input  wire logic [4:0] pin_oe,
    output logic [4:0]      pin_i,
    // Board resistors fitted, and their levels
    input  wire logic [4:0] strap_en,
    input  wire logic [4:0] strap_val,
    // Modem conditions, 1 = asserted: cts, dsr, dcd, ring
    input  wire logic [3:0] ask_a,
    input  wire logic [3:0] ask_b,
    output logic [3:0]      modem_a_n,
    output logic [3:0]      modem_b_n
);
    // Released pin falls to fitted resistor, else internal pull; never keeps last level
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ((strap_en & strap_val) | (~strap_en & PULL)));
    // Modem lines are active low
    assign modem_a_n = ~ask_a;
    assign modem_b_n = ~ask_b;
endmodule

// [bench/tb.sv]
// Self-checking bench for the serial pin block
`timescale 1ns/100ps
`include "dspps_defs.svh"
module tb;
    // Design pins, named as the ports for a wildcard hookup
    logic        aclk, aresetn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        serial_in_chan_a, serial_in_chan_b, infrared_rx_second, infrared_tx_second, terminal_ready_b_n;
    logic        ring_indication_a_n, carrier_detect_a_n, dataset_ready_a_n, clear_to_send_a_n;
    logic        ring_indication_b_n, carrier_detect_b_n, dataset_ready_b_n, clear_to_send_b_n;
    logic        terminal_ready_a_i, terminal_ready_a_o, terminal_ready_a_oe;
    logic        request_send_a_i, request_send_a_o, request_send_a_oe;
    logic        serial_out_chan_a_i, serial_out_chan_a_o, serial_out_chan_a_oe;
    logic        request_send_b_i, request_send_b_o, request_send_b_oe;
    logic        serial_out_chan_b_i, serial_out_chan_b_o, serial_out_chan_b_oe;
    logic        index_port_select_bit, pnp_defaults_bit, floppy_enable, serial_irq_mode;
    logic        pin_zero_irq_gpio_select, pin_one_irq_gpio_select;
    // Bench state
    logic [4:0]  pin_o, pin_oe, pin_i, strap_en, strap_val;
    logic [3:0]  ask_a, ask_b, modem_a_n, modem_b_n;
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          n_fail, cmp_count, cyc, wcyc;

    // Pin bundles toward the far side model
    assign pin_o = {request_send_b_o, serial_out_chan_b_o, serial_out_chan_a_o, request_send_a_o, terminal_ready_a_o};
    assign pin_oe = {request_send_b_oe, serial_out_chan_b_oe, serial_out_chan_a_oe, request_send_a_oe,
                     terminal_ready_a_oe};
    assign {request_send_b_i, serial_out_chan_b_i, serial_out_chan_a_i, request_send_a_i, terminal_ready_a_i} = pin_i;
    assign {clear_to_send_a_n, dataset_ready_a_n, carrier_detect_a_n, ring_indication_a_n} = modem_a_n;
    assign {clear_to_send_b_n, dataset_ready_b_n, carrier_detect_b_n, ring_indication_b_n} = modem_b_n;

    dspps_top u_dut (.*);
    dspps_modem u_modem (.*);

    always #20 aclk = ~aclk;

    // Hang guard, well above the longest expected run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        wcyc = 0;
        do begin
            @(posedge aclk);
            wcyc++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
    endtask

    task automatic axr(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    // Reset with straps fitted; latched values must outlive the resistors
    task automatic rst(input logic [4:0] en, input logic [4:0] val);
        logic [4:0] e = (en & val) | (~en & 5'h06);
        aresetn <= 1'b0;
        strap_en <= en;
        strap_val <= val;
        repeat (20) @(posedge aclk);
        chk("oe in reset", pin_oe, 0);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("oe after release", pin_oe, 5'h1F);
        strap_en <= 5'h00;
        chk("strap outs", {pin_one_irq_gpio_select, pin_zero_irq_gpio_select, serial_irq_mode, floppy_enable,
            pnp_defaults_bit, index_port_select_bit}, {{2{e[4]}}, e[3:0]});
        axr(`DSPPS_OFF_STRAP);
        chk("strap reg", rd[5:0], {e[4], e[4], 1'b0, e[1], 1'b0, e[0]});
        axr(`DSPPS_OFF_STRAP_AUX);
        chk("strap aux", rd[1:0], {e[3], e[2]});
        $display("test reset %h done", en);
    endtask

    task automatic t_status();
        ask_a <= 4'h5;
        ask_b <= 4'hA;
        serial_in_chan_a <= 1'b1;
        axr(`DSPPS_OFF_STAT_A);
        chk("stat a", rd[4:0], 5'h15);
        axr(`DSPPS_OFF_STAT_B);
        chk("stat b", rd[4:0], 5'h0A);
        axr(32'h0000_0020);
        chk("unmapped read", {rd, rsp}, 34'h2);
        axw(32'h0000_0020, 32'h0000_0001);
        chk("unmapped write", rsp, 2'h2);
        $display("test status done");
    endtask

    task automatic t_ctrl();
        axw(`DSPPS_OFF_CTRL, 32'h0000_000F);
        chk("ctl on", {request_send_b_o, terminal_ready_b_n, request_send_a_o, terminal_ready_a_o}, 0);
        axw(`DSPPS_OFF_CTRL, 32'h0000_0010);
        chk("ctl off", {request_send_b_o, terminal_ready_b_n, request_send_a_o, terminal_ready_a_o}, 15);
        infrared_rx_second <= 1'b1;
        axr(`DSPPS_OFF_STAT_B);
        chk("ir rx", rd[0], 1'b1);
        chk("ir tx idle", infrared_tx_second, 1'b1);
        axw(`DSPPS_OFF_TXDATA, 32'h0000_0100);
        @(posedge aclk);
        chk("ir start", {infrared_tx_second, serial_out_chan_b_o}, 2'h1);
        repeat (2200) @(posedge aclk);
        axw(`DSPPS_OFF_CTRL, 32'h0000_0000);
        $display("test ctrl done");
    endtask

    // One frame on channel B, sampled mid-bit
    task automatic t_frame();
        logic [9:0] got;
        axw(`DSPPS_OFF_TXDATA, 32'h0000_0155);
        wcyc = 0;
        while (serial_out_chan_b_o && wcyc < 500) begin
            @(posedge aclk);
            wcyc++;
        end
        repeat (108) @(posedge aclk);
        for (int i = 0; i < 10; i++) begin
            got[i] = serial_out_chan_b_o;
            repeat (217) @(posedge aclk);
        end
        chk("frame b", got, 10'h2AA);
        $display("test frame done");
    endtask

    // Fill until refused, then drain both channels to empty
    task automatic t_fifo();
        int  n;
        logic b;
        for (int i = 0; i < 34; i++) axw(`DSPPS_OFF_TXDATA, {23'h0, i[0], i[7:0]});
        axr(`DSPPS_OFF_TXDATA);
        chk("room when full", rd[0], 1'b0);
        axw(`DSPPS_OFF_TXDATA, 32'h0000_0000);
        chk("write held while full", wcyc > 200, 1'b1);
        n = 0;
        do begin
            repeat (200) @(posedge aclk);
            axr(`DSPPS_OFF_STAT_A);
            b = rd[5];
            axr(`DSPPS_OFF_STAT_B);
            n++;
        end while ((b || rd[5]) && n < 300);
        chk("drained", {b, rd[5]}, 0);
        axr(`DSPPS_OFF_TXDATA);
        chk("room when empty", rd[0], 1'b1);
        $display("test fifo done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {serial_in_chan_a, serial_in_chan_b, infrared_rx_second, ask_a, ask_b, strap_en, strap_val} = '0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        rst(5'h00, 5'h00);
        t_status();
        t_ctrl();
        t_frame();
        t_fifo();
        rst(5'h1F, 5'h19);
        print_verdict();
    end
endmodule
